// File: dotw_pkg.sv
package dotw_pkg;

  // ----------------------------------------------------------------
  // Clock and timing figures
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int LAT_OFFSET = 2;
  localparam int CHOP_EXTRA_CK = 4;
  localparam int FULL_EXTRA_CK = 6;
  localparam int TERM_HIGH_MIN_LONG_BURST = 6;
  localparam int TERM_HIGH_MIN_SHORT = 4;
  localparam int SETTLE_MIN_TENTHS = 3;
  localparam int SETTLE_MAX_TENTHS = 7;
  localparam int ASYNC_MIN_PS = 2000;
  localparam int ASYNC_MAX_PS = 8500;
  localparam int ASYNC_MIN_CYC = (ASYNC_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ASYNC_MAX_CYC = ASYNC_MAX_PS / CLK_PERIOD_PS;
  localparam int LEVEL_FIRST_STROBE_DELAY = 40;
  localparam int LEVEL_FEEDBACK_DELAY_PS = 9000;
  localparam int LEVEL_FEEDBACK_FAST_PS = 7500;
  localparam int LEVEL_FEEDBACK_CYC = LEVEL_FEEDBACK_FAST_PS / CLK_PERIOD_PS;
  localparam int LEVEL_FEEDBACK_SKEW_PS = 2000;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int LAT_W = 5;
  localparam int HIST_DEPTH = 32;
  localparam int CNT_W = 7;
  localparam int FB_W = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_SYNC = 2'h0,
    ST_ASYNC = 2'h1,
    ST_LEVEL = 2'h3
  } dotw_mode_e;

  typedef struct packed {
    logic [LAT_W-1:0] write_latency_setting;
    logic [LAT_W-1:0] additive_latency;
    logic dyn_term_en;
  } dotw_cfg_s;

  typedef struct packed {
    logic wr_valid;
    logic four_beat_chop;
  } dotw_wr_s;

endpackage : dotw_pkg

// File: dotw_core.sv
`timescale 1ns/1ps
`default_nettype none
module dotw_core (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Static configuration and power state
  input wire dotw_pkg::dotw_cfg_s cfg_i,
  input wire logic power_down_i,
  input wire logic dll_off_i,
  input wire logic level_mode_i,
  // Decoded write command
  input wire dotw_pkg::dotw_wr_s wr_i,
  // Pins from the controller
  input wire logic term_en_pin_i,
  input wire logic strobe_pin_i,
  input wire logic clk_level_pin_i,
  // Termination and leveling outputs
  output logic term_on_o,
  output logic term_write_sel_o,
  output logic [dotw_pkg::FB_W-1:0] level_fb_o,
  output logic level_ready_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic term_s1_q, term_s2_q;
  logic strobe_s1_q, strobe_s2_q, strobe_s3_q;
  logic lvl_s1_q, lvl_s2_q;

  // Two stages before any logic looks at a pin
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      term_s1_q <= 1'b0;
      term_s2_q <= 1'b0;
      strobe_s1_q <= 1'b0;
      strobe_s2_q <= 1'b0;
      strobe_s3_q <= 1'b0;
      lvl_s1_q <= 1'b0;
      lvl_s2_q <= 1'b0;
    end else begin
      term_s1_q <= term_en_pin_i;
      term_s2_q <= term_s1_q;
      strobe_s1_q <= strobe_pin_i;
      strobe_s2_q <= strobe_s1_q;
      strobe_s3_q <= strobe_s2_q; // Old value for edge detect only
      lvl_s1_q <= clk_level_pin_i;
      lvl_s2_q <= lvl_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------
  dotw_pkg::dotw_mode_e mode_q, mode_d;

  // Leveling wins; power-down with the loop off falls back to async
  always_comb begin
    mode_d = dotw_pkg::ST_SYNC;
    if (level_mode_i) begin
      mode_d = dotw_pkg::ST_LEVEL;
    end else if (power_down_i && dll_off_i) begin
      mode_d = dotw_pkg::ST_ASYNC;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q <= dotw_pkg::ST_SYNC;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ----------------------------------------------------------------
  // Latency arithmetic
  // ----------------------------------------------------------------
  localparam logic [dotw_pkg::LAT_W:0] LAT_OFF = (dotw_pkg::LAT_W+1)'(dotw_pkg::LAT_OFFSET);
  localparam logic [dotw_pkg::LAT_W:0] LAT_MAX = (dotw_pkg::LAT_W+1)'(dotw_pkg::HIST_DEPTH - 1);
  localparam logic [dotw_pkg::LAT_W:0] LAT_ONE = (dotw_pkg::LAT_W+1)'(1);
  logic [dotw_pkg::LAT_W:0] wl_sum;
  logic [dotw_pkg::LAT_W:0] term_lat;

  // Sum is the write latency; clamp keeps the delay line addressable
  always_comb begin
    wl_sum = {1'b0, cfg_i.write_latency_setting} + {1'b0, cfg_i.additive_latency};
    if (wl_sum <= LAT_OFF) begin
      term_lat = LAT_ONE;
    end else if (wl_sum - LAT_OFF > LAT_MAX) begin
      term_lat = LAT_MAX;
    end else begin
      term_lat = wl_sum - LAT_OFF;
    end
  end

  // ----------------------------------------------------------------
  // Synchronous termination delay line
  // ----------------------------------------------------------------
  logic [dotw_pkg::HIST_DEPTH-1:0] hist_q;
  logic sampling;

  assign sampling = (mode_q == dotw_pkg::ST_SYNC);

  // One entry per real clock edge, so latency counts true edges
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hist_q <= '0;
    end else if (sampling) begin
      hist_q <= {hist_q[dotw_pkg::HIST_DEPTH-2:0], term_s2_q};
    end else begin
      hist_q <= '0;
    end
  end

  // Output edge is the reference point; the analog ramp of 0.3 to 0.7
  // clock sits inside the following cycle and is not modelled here
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      term_on_o <= 1'b0;
    end else begin
      case (mode_q)
        dotw_pkg::ST_SYNC: term_on_o <= hist_q[term_lat[dotw_pkg::LAT_W-1:0] - 5'h01];
        dotw_pkg::ST_ASYNC: term_on_o <= term_s2_q;
        dotw_pkg::ST_LEVEL: term_on_o <= term_s2_q;
        default: term_on_o <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Dynamic termination scheduler
  // ----------------------------------------------------------------
  localparam logic [dotw_pkg::CNT_W-1:0] CNT_ONE = dotw_pkg::CNT_W'(1);
  localparam logic [dotw_pkg::CNT_W-1:0] CHOP_X = dotw_pkg::CNT_W'(dotw_pkg::CHOP_EXTRA_CK);
  localparam logic [dotw_pkg::CNT_W-1:0] FULL_X = dotw_pkg::CNT_W'(dotw_pkg::FULL_EXTRA_CK);
  logic dyn_busy_q;
  logic [dotw_pkg::CNT_W-1:0] dyn_cnt_q;
  logic [dotw_pkg::CNT_W-1:0] on_pt_q;
  logic [dotw_pkg::CNT_W-1:0] off_pt_q;
  logic [dotw_pkg::CNT_W-1:0] on_pt_d;
  logic dyn_start;

  assign dyn_start = wr_i.wr_valid && cfg_i.dyn_term_en && (mode_q == dotw_pkg::ST_SYNC);
  assign on_pt_d = dotw_pkg::CNT_W'(term_lat);

  // A new write restarts the schedule, stretching write termination
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dyn_busy_q <= 1'b0;
      dyn_cnt_q <= '0;
      on_pt_q <= '0;
      off_pt_q <= '0;
    end else if (dyn_start) begin
      dyn_busy_q <= 1'b1;
      dyn_cnt_q <= CNT_ONE;
      on_pt_q <= on_pt_d;
      off_pt_q <= on_pt_d + (wr_i.four_beat_chop ? CHOP_X : FULL_X);
    end else if (dyn_busy_q) begin
      dyn_cnt_q <= dyn_cnt_q + CNT_ONE;
      if (dyn_cnt_q == off_pt_q || mode_q != dotw_pkg::ST_SYNC) begin
        dyn_busy_q <= 1'b0;
      end
    end
  end

  // Select changes on the scheduled edge; settle window follows it
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      term_write_sel_o <= 1'b0;
    end else if (!dyn_busy_q || mode_q != dotw_pkg::ST_SYNC) begin
      term_write_sel_o <= 1'b0;
    end else if (dyn_cnt_q == off_pt_q) begin
      term_write_sel_o <= 1'b0;
    end else if (dyn_cnt_q == on_pt_q) begin
      term_write_sel_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Write leveling
  // ----------------------------------------------------------------
  localparam logic [dotw_pkg::CNT_W-1:0] FIRST_STROBE = dotw_pkg::CNT_W'(dotw_pkg::LEVEL_FIRST_STROBE_DELAY);
  logic [dotw_pkg::CNT_W-1:0] lvl_cnt_q;
  logic strobe_rise;

  assign strobe_rise = strobe_s2_q && !strobe_s3_q;

  // Strobes before the entry delay are ignored rather than trusted
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lvl_cnt_q <= '0;
      level_ready_o <= 1'b0;
    end else if (mode_q != dotw_pkg::ST_LEVEL) begin
      lvl_cnt_q <= '0;
      level_ready_o <= 1'b0;
    end else if (lvl_cnt_q != FIRST_STROBE) begin
      lvl_cnt_q <= lvl_cnt_q + CNT_ONE;
      level_ready_o <= (lvl_cnt_q + CNT_ONE) == FIRST_STROBE;
    end
  end

  // One flop per lane, all loaded on the same edge, so lane skew is nil
  genvar g;
  generate
    for (g = 0; g < dotw_pkg::FB_W; g++) begin : g_fb
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          level_fb_o[g] <= 1'b0;
        end else if (mode_q != dotw_pkg::ST_LEVEL) begin
          level_fb_o[g] <= 1'b0;
        end else if (strobe_rise && level_ready_o) begin
          level_fb_o[g] <= lvl_s2_q;
        end
      end
    end
  endgenerate

endmodule : dotw_core
`default_nettype wire

// File: dotw_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dotw_asserts (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Inputs
  input wire dotw_pkg::dotw_cfg_s cfg_i,
  input wire logic power_down_i,
  input wire logic dll_off_i,
  input wire logic level_mode_i,
  input wire dotw_pkg::dotw_wr_s wr_i,
  input wire logic term_en_pin_i,
  input wire logic strobe_pin_i,
  input wire logic clk_level_pin_i,
  // Outputs
  input wire logic term_on_o,
  input wire logic term_write_sel_o,
  input wire logic [dotw_pkg::FB_W-1:0] level_fb_o,
  input wire logic level_ready_o
);
  logic [1:0] ts_q, cs_q;
  logic [2:0] ss_q;
  logic [39:0] th_q, wh_q, wc_q;
  logic [5:0] sc_q, ac_q, lc_q, sum, lat;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  function automatic logic [5:0] age(input logic [5:0] v, input logic c);
    return c ? ((v == 6'h3F) ? v : v + 6'h01) : 6'h00;
  endfunction : age
  // Latency clamped to the legal 1..31 range
  always_comb begin
    sum = 6'(cfg_i.write_latency_setting) + 6'(cfg_i.additive_latency);
    lat = (sum < 6'h03) ? 6'h01 : (sum > 6'h21) ? 6'h1F : sum - 6'h02;
  end
  // Mode ages restart on any mode change, so stale delay-line contents are waited out
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {ts_q, cs_q, ss_q, th_q, wh_q, wc_q, sc_q, ac_q, lc_q} <= '0;
    end else begin
      ts_q <= {ts_q[0], term_en_pin_i};
      cs_q <= {cs_q[0], clk_level_pin_i};
      ss_q <= {ss_q[1:0], strobe_pin_i};
      th_q <= {th_q[38:0], ts_q[1]};
      wh_q <= {wh_q[38:0], wr_i.wr_valid & cfg_i.dyn_term_en};
      // Chop writes kept apart so each burst length is held to its own return point
      wc_q <= {wc_q[38:0], wr_i.wr_valid & cfg_i.dyn_term_en & wr_i.four_beat_chop};
      sc_q <= age(sc_q, !level_mode_i && !(power_down_i && dll_off_i));
      ac_q <= age(ac_q, !level_mode_i && power_down_i && dll_off_i);
      lc_q <= age(lc_q, level_mode_i);
    end
  end
  // Output register adds one stage behind the delay line tap, hence index lat
  term_lat_a: assert property (sc_q >= 6'h24 |-> term_on_o == th_q[lat])
    else $error("termination latency");
  async_on_a: assert property (ac_q >= 6'h04 |-> term_on_o == th_q[0])
    else $error("async termination");
  sel_rise_a: assert property (sc_q >= 6'h24 && $rose(term_write_sel_o) |-> wh_q[lat])
    else $error("write termination start");
  sel_fall_a: assert property (sc_q >= 6'h24 && $fell(term_write_sel_o) |->
    wc_q[lat + 6'h04] || (wh_q[lat + 6'h06] && !wc_q[lat + 6'h06]))
    else $error("write termination end");
  fb_load_a: assert property (level_ready_o && $rose(ss_q[1]) |=> level_fb_o == {dotw_pkg::FB_W{$past(cs_q[1])}})
    else $error("leveling feedback");
  ready_early_a: assert property (lc_q inside {[6'h01:6'h26]} |-> !level_ready_o)
    else $error("ready early");
  ready_late_a: assert property (lc_q >= 6'h2A |-> level_ready_o)
    else $error("ready late");
  fb_clear_a: assert property ($fell(level_mode_i) |-> ##2 level_fb_o == '0 && !level_ready_o)
    else $error("leveling exit");
  cover property (sc_q >= 6'h24 && $fell(term_write_sel_o) && wh_q[lat + 6'h04]);
  cover property (ac_q >= 6'h04 && $rose(term_on_o));
  cover property (level_ready_o && $rose(ss_q[1]));
endmodule : dotw_asserts
bind dotw_core dotw_asserts i_dotw_asserts (.core_clk_i, .rst_i, .cfg_i, .power_down_i, .dll_off_i, .level_mode_i,
  .wr_i, .term_en_pin_i, .strobe_pin_i, .clk_level_pin_i, .term_on_o, .term_write_sel_o, .level_fb_o, .level_ready_o);
`default_nettype wire

// File: dotw_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module dotw_ctrl_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Requests from the bench
  input wire logic req_i,
  input wire logic wr_i,
  input wire logic chop_i,
  input wire logic level_mode_i,
  // Pins towards the device
  output logic term_en_pin_o,
  output dotw_pkg::dotw_wr_s wr_o,
  output logic strobe_pin_o
);
  logic [5:0] hold_q, lvl_q;
  // Falling-edge drive keeps pins settled at the device's rising edge
  always_ff @(negedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {hold_q, lvl_q, term_en_pin_o, wr_o, strobe_pin_o} <= '0;
    end else begin
      wr_o <= {req_i & wr_i, chop_i};
      // Random slack of up to two clocks plays a slow controller
      if (req_i) hold_q <= (wr_i && !chop_i ? 6'h06 : 6'h04) + 6'($urandom_range(2));
      else if (hold_q != 6'h00) hold_q <= hold_q - 6'h01;
      term_en_pin_o <= req_i || hold_q > 6'h01;
      // Strobes only after the entry delay, then one every eight clocks
      lvl_q <= !level_mode_i ? 6'h00 : (lvl_q == 6'h3F) ? 6'h30 : lvl_q + 6'h01;
      strobe_pin_o <= level_mode_i && lvl_q >= 6'h2C && lvl_q[2];
    end
  end
endmodule : dotw_ctrl_model
`default_nettype wire

// File: dram_odt_write_leveling_timing_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dram_odt_write_leveling_timing_tb;
  logic clk = 1'b0, rst = 1'b1, pd = 1'b1, dll = 1'b1, lvl = 1'b0, clv = 1'b0;
  logic req = 1'b0, wrq = 1'b0, chop = 1'b0, pin, strb, on, sel, rdy;
  logic [dotw_pkg::FB_W-1:0] fb;
  dotw_pkg::dotw_cfg_s cfg = '0;
  dotw_pkg::dotw_wr_s wr;
  int err_total = 0, check_count = 0, n;
  always #2 clk = ~clk;
  dotw_ctrl_model i_dotw_ctrl_model (.core_clk_i(clk), .rst_i(rst), .req_i(req), .wr_i(wrq), .chop_i(chop),
    .level_mode_i(lvl), .term_en_pin_o(pin), .wr_o(wr), .strobe_pin_o(strb));
  dotw_core i_dotw_core (.core_clk_i(clk), .rst_i(rst), .cfg_i(cfg), .power_down_i(pd), .dll_off_i(dll),
    .level_mode_i(lvl), .wr_i(wr), .term_en_pin_i(pin), .strobe_pin_i(strb), .clk_level_pin_i(clv),
    .term_on_o(on), .term_write_sel_o(sel), .level_fb_o(fb), .level_ready_o(rdy));
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  function automatic int sel_exp(input logic w, input logic c, input logic d);
    return (w && d) ? (c ? 4 : 6) : 0;
  endfunction : sel_exp
  // Widths are compared, so the check holds for any latency setting
  task automatic op(input logic w, input logic c, input logic d);
    int p, a, b;
    {p, a, b} = '0;
    req <= 1'b1;
    wrq <= w;
    chop <= c;
    @(negedge clk) req <= 1'b0;
    repeat (60) begin
      @(negedge clk);
      p += int'(pin === 1'b1);
      a += int'(on === 1'b1);
      b += int'(sel === 1'b1);
    end
    chk(p >= ((w && !c) ? 6 : 4), "enable width");
    chk(a == p, "termination width");
    chk(b == sel_exp(w, c, d), "write termination width");
  endtask : op
  // Latency is changed only when power-down is raised, never under sync traffic
  initial begin
    void'($urandom(32'h2A171FC8));
    repeat (6) @(posedge clk);
    @(negedge clk) rst <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      pd <= 1'b1;
      cfg <= k == 0 ? 11'h041 : k == 1 ? 11'h7FF : {5'($urandom_range(5, 12)), 5'($urandom_range(6)), k != 2};
      repeat (6) @(negedge clk);
      op(1'b1, k[0], 1'b0);
      pd <= 1'b0;
      repeat (40) @(negedge clk);
      op(k != 5, k[0], k != 2);
      $display("pass %0d done", k);
    end
    lvl <= 1'b1;
    for (int j = 0; j < 4; j++) begin
      clv <= 1'($urandom_range(1));
      for (n = 0; n < 100 && strb !== 1'b1; n++) @(negedge clk);
      if (n == 100) begin
        err_total++;
        $display("CHECK FAILED %0t strobe timeout", $time);
        break;
      end
      repeat (5) @(negedge clk);
      chk(fb === {dotw_pkg::FB_W{clv}} && rdy === 1'b1, "leveling feedback");
    end
    lvl <= 1'b0;
    repeat (4) @(negedge clk);
    chk(fb === '0 && rdy === 1'b0, "leveling exit");
    $display("leveling done");
    complete_run();
  end
endmodule : dram_odt_write_leveling_timing_tb
`default_nettype wire
